/* File: shared/rpc_regs.svh */
`ifndef RPC_REGS_SVH
`define RPC_REGS_SVH

// Clock and bit timing
`define RPC_CLK_MHZ 40
`define RPC_BIT_NS 100
`define RPC_BIT_CYC ((`RPC_BIT_NS * `RPC_CLK_MHZ) / 1000)
`define RPC_CRS_PERIOD_NS 1000
`define RPC_CRS_PERIOD_CYC ((`RPC_CRS_PERIOD_NS * `RPC_CLK_MHZ) / 1000)

// Frame timing counts, in bit times
`define RPC_PREAMBLE_BITS 8'h38
`define RPC_LOCKOUT_BITS 8'h60
`define RPC_JABBER_BITS 65536

// Carrier sense serial output
`define RPC_CRS_BITS 4'h9
`define RPC_STR_CYC 2'h2

// Reset values
`define RPC_SO_RESET 1'h1
`define RPC_REQ_N_RESET 1'h1

`endif

/* File: shared/rpc_pkg.sv */
package rpc_pkg;

    localparam int NPORT = 9;

    typedef enum logic [2:0] {
        RPC_IDLE = 3'b000,
        RPC_PRE = 3'b001,
        RPC_DATA = 3'b010,
        RPC_JAM = 3'b011,
        RPC_LOCK = 3'b100
    } rpc_tx_t;

    typedef struct packed {
        logic ack_n;
        logic col_n;
        logic jam;
        logic dat;
    } rpc_exp_in_t;

    typedef struct packed {
        logic req_n;
        logic jam_o;
        logic jam_oe;
        logic dat_o;
        logic dat_oe;
    } rpc_exp_out_t;

    typedef struct packed {
        logic [NPORT-1:0] pol_sqe;
        logic [NPORT-1:0] rate_err;
        logic [NPORT-1:0] link_loop;
        logic [NPORT-1:0] part;
    } rpc_min_status_t;

endpackage : rpc_pkg

/* File: hw/rpc_sync.sv */
`timescale 1ns/1ps

module rpc_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] q;
    } rpc_sync_t;

    rpc_sync_t s;
    rpc_sync_t next_s;

    if (WIDTH < 1) begin : g_bad
        $error("rpc_sync: WIDTH must be at least 1");
    end

    always_comb begin
        next_s.meta = d;
        next_s.q = s.meta;
    end

    // Runs through reset so idle pin levels are settled at release
    always_ff @(posedge clk) begin
        s <= next_s;
    end

    assign q = s.q;

endmodule : rpc_sync

/* File: hw/rpc_fifo.sv */
`timescale 1ns/1ps

module rpc_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic full;
        logic empty;
    } rpc_fifo_t;

    rpc_fifo_t s;
    rpc_fifo_t next_s;

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
        $error("rpc_fifo: DEPTH must be a power of two, at least 2");
    end

    always_comb begin
        logic push;
        logic pop;
        push = in_valid & ~s.full;
        pop = out_ready & ~s.empty;
        next_s = s;
        if (push) begin
            next_s.mem[s.wp] = in_data;
            next_s.wp = s.wp + 1'b1;
        end
        if (pop) begin
            next_s.rp = s.rp + 1'b1;
        end
        if (push && !pop) begin
            next_s.cnt = s.cnt + 1'b1;
        end else if (pop && !push) begin
            next_s.cnt = s.cnt - 1'b1;
        end
        next_s.full = (next_s.cnt == (AW + 1)'(DEPTH));
        next_s.empty = (next_s.cnt == '0);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '{mem: '0, wp: '0, rp: '0, cnt: '0, full: 1'b0, empty: 1'b1};
        end else begin
            s <= next_s;
        end
    end

    assign in_ready = ~s.full;
    assign out_valid = ~s.empty;
    assign out_data = s.mem[s.rp];

endmodule : rpc_fifo

/* File: hw/rpc_top.sv */
// Overview of operation
// - While jam is driven, data low means multiport, high single-port collision.
// - Jam and data float without grant, drive with request and grant, else listen.
// - Request low while any port receives or collides, or FIFO still sends.
// - Serial data moves on serial clock rising edges, asynchronous, up to 10 MHz.
// - Normal mode: commands shift in on serial input, results out on serial output.
// - Minimum mode latches serial input at reset release as polarity correction enable.
// - Minimum mode serial output streams status chosen by serial clock and input.
// - Test high at reset release selects minimum mode; test high allows loopback.
// - Store strobe goes high for two cycles, one cycle after the ninth carrier bit shifts out.
// - Per-port carrier is latched between samples so short activity is kept.
// - With the statistics chip present, store pin becomes an input after reset.
// - A valid packet is repeated to all other ports and onto expansion data.
// - Repeated packets carry at least 56 regenerated preamble bits.
// - Over 65536 bit times transmitting cuts transmitters off for 96 bit times.
// - Jabber lockup state is read by a management status command as one bit.
// - Expansion collision status drives transmit and one-port-left collision handling.
// - Outside collisions the active device drives repeated data with preamble.
// - Expansion collision input makes every device produce its own jam.
`timescale 1ns/1ps
`include "rpc_regs.svh"

module rpc_top #(
    parameter int NPORT = 9,
    parameter int JABBER_BITS = `RPC_JABBER_BITS,
    parameter int CMD_BITS = 8,
    parameter logic [CMD_BITS-1:0] OP_JABBER = 8'hA5,
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Port carrier, collision and status pins
    input wire logic [NPORT-1:0] port_crs,
    input wire logic [NPORT-1:0] port_col,
    input wire rpc_pkg::rpc_min_status_t min_status,
    // Received NRZ bits from the decoder
    input wire logic rx_valid,
    input wire logic rx_bit,
    output logic rx_ready,
    // Transmit side
    output logic [NPORT-1:0] tx_en,
    output logic tx_bit,
    // Expansion port
    input wire rpc_pkg::rpc_exp_in_t exp_in,
    output rpc_pkg::rpc_exp_out_t exp_out,
    // Carrier sense serial output and store strobe
    output logic carrier_sense_serial_out,
    input wire logic store_strobe_i,
    output logic store_strobe_o,
    output logic store_strobe_oe,
    input wire logic stat_chip_present,
    // Serial management port
    input wire logic sclk,
    input wire logic si,
    output logic so,
    input wire logic test,
    // Mode and status
    output logic minimum_mode,
    output logic polarity_correct_en,
    output logic loopback_allowed,
    output logic jabber_lockup,
    output logic store_strobe_in
);

    localparam int BIT_CYC = `RPC_BIT_CYC;
    localparam int CRS_CYC = `RPC_CRS_PERIOD_CYC;
    localparam int JW = $clog2(JABBER_BITS) + 2;
    localparam int NS = 2 * NPORT + 9;

    if (NPORT != rpc_pkg::NPORT || CMD_BITS < 2 || JABBER_BITS < 2) begin : g_bad
        $error("rpc_top: unsupported parameter values");
    end

    // ***********************
    // State
    // ***********************
    typedef struct packed {
        rpc_pkg::rpc_tx_t tx;
        logic [3:0] bdiv;
        logic [7:0] pre_cnt;
        logic [JW-1:0] jab_cnt;
        logic [7:0] lock_cnt;
        logic jabber;
        rpc_pkg::rpc_exp_out_t exp;
        logic [NPORT-1:0] tx_en;
        logic tx_bit;
        logic [NPORT-1:0] crs_latch;
        logic [NPORT-1:0] crs_shift;
        logic [3:0] crs_left;
        logic [5:0] crs_timer;
        logic crs_o;
        logic [1:0] str_cnt;
        logic str_o;
        logic str_oe;
        logic rst_d;
        logic min_mode;
        logic pol_en;
        logic sclk_d;
        logic [CMD_BITS-1:0] cmd;
        logic [CMD_BITS-1:0] resp;
        logic [7:0] bcnt;
        logic [3:0] midx;
        logic so;
    } rpc_state_t;

    rpc_state_t s;
    rpc_state_t next_s;

    // ***********************
    // Pin synchronisers
    // ***********************
    logic [NS-1:0] sync_q;
    logic [NPORT-1:0] crs_s;
    logic [NPORT-1:0] pcol_s;
    logic ack_n_s, col_n_s, jam_s, dat_s, sclk_s, si_s, test_s, str_s, paired_s;

    rpc_sync #(.WIDTH(NS)) u_sync (
        .clk(clk),
        .rst(rst),
        .d({port_crs, port_col, exp_in.ack_n, exp_in.col_n, exp_in.jam, exp_in.dat,
            sclk, si, test, store_strobe_i, stat_chip_present}),
        .q(sync_q)
    );

    assign {crs_s, pcol_s, ack_n_s, col_n_s, jam_s, dat_s, sclk_s, si_s, test_s, str_s,
            paired_s} = sync_q;

    // ***********************
    // Data FIFO
    // ***********************
    logic fifo_valid;
    logic fifo_data;
    logic fifo_pop;

    rpc_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(rx_valid),
        .in_ready(rx_ready),
        .in_data(rx_bit),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    function automatic logic [3:0] pop_count(input logic [NPORT-1:0] v);
        logic [3:0] c;
        c = '0;
        for (int i = 0; i < NPORT; i++) begin
            c = c + {3'h0, v[i]};
        end
        return c;
    endfunction : pop_count

    // ***********************
    // Next state
    // ***********************
    always_comb begin
        logic bit_en, granted, listen, coll, single, busy, rise;
        logic [3:0] nact;
        logic [NPORT-1:0] sel;
        next_s = s;
        sel = '0;
        fifo_pop = 1'b0;
        bit_en = (s.bdiv == '0);
        nact = pop_count(crs_s | pcol_s);
        coll = (nact > 4'h1) | (|pcol_s) | ~col_n_s;
        single = (nact == 4'h1) & col_n_s;
        granted = ~ack_n_s & ~s.exp.req_n;
        listen = ~ack_n_s & s.exp.req_n;
        rise = sclk_s & ~s.sclk_d;
        next_s.sclk_d = sclk_s;
        next_s.rst_d = 1'b0;
        next_s.bdiv = (s.bdiv == 4'(BIT_CYC - 1)) ? '0 : s.bdiv + 1'b1;

        // Straps caught on the first cycle after reset release
        if (s.rst_d) begin
            next_s.min_mode = test_s;
            next_s.pol_en = test_s & si_s;
            next_s.str_oe = ~paired_s;
        end

        // Repeat, preamble, collision and jabber
        if (bit_en) begin
            unique case (s.tx)
                rpc_pkg::RPC_IDLE: begin
                    next_s.jab_cnt = '0;
                    next_s.tx_en = '0;
                    if (coll) begin
                        next_s.tx = rpc_pkg::RPC_JAM;
                    end else if (|crs_s) begin
                        next_s.tx = rpc_pkg::RPC_PRE;
                        next_s.pre_cnt = '0;
                        next_s.tx_bit = 1'b1;
                    end else if (listen) begin
                        next_s.tx_en = '1;
                        next_s.tx_bit = dat_s;
                    end
                end
                rpc_pkg::RPC_PRE: begin
                    if (s.pre_cnt == `RPC_PREAMBLE_BITS - 8'h1) begin
                        next_s.tx = rpc_pkg::RPC_DATA;
                        fifo_pop = fifo_valid;
                        next_s.tx_bit = fifo_valid ? fifo_data : s.tx_bit;
                    end else begin
                        next_s.tx_bit = ~s.tx_bit;
                        next_s.pre_cnt = s.pre_cnt + 1'b1;
                    end
                end
                rpc_pkg::RPC_DATA: begin
                    if (fifo_valid) begin
                        fifo_pop = 1'b1;
                        next_s.tx_bit = fifo_data;
                    end else if (!(|crs_s)) begin
                        next_s.tx = rpc_pkg::RPC_IDLE;
                    end
                end
                rpc_pkg::RPC_JAM: begin
                    next_s.tx_bit = ~s.tx_bit;
                    fifo_pop = fifo_valid;
                    if (!coll) begin
                        next_s.tx = rpc_pkg::RPC_IDLE;
                    end
                end
                rpc_pkg::RPC_LOCK: begin
                    next_s.lock_cnt = s.lock_cnt - 1'b1;
                    if (s.lock_cnt == 8'h1) begin
                        next_s.tx = rpc_pkg::RPC_IDLE;
                        next_s.jabber = 1'b0;
                    end
                end
                default: begin
                    next_s.tx = rpc_pkg::RPC_IDLE;
                end
            endcase
            if (s.tx inside {rpc_pkg::RPC_PRE, rpc_pkg::RPC_DATA, rpc_pkg::RPC_JAM}) begin
                next_s.jab_cnt = s.jab_cnt + 1'b1;
                if (s.jab_cnt == JW'(JABBER_BITS)) begin
                    next_s.tx = rpc_pkg::RPC_LOCK;
                    next_s.lock_cnt = `RPC_LOCKOUT_BITS;
                    next_s.jabber = 1'b1;
                end
            end
            if (coll && next_s.tx inside {rpc_pkg::RPC_PRE, rpc_pkg::RPC_DATA}) begin
                next_s.tx = rpc_pkg::RPC_JAM;
            end
            unique case (next_s.tx)
                rpc_pkg::RPC_PRE, rpc_pkg::RPC_DATA: next_s.tx_en = ~crs_s;
                rpc_pkg::RPC_JAM: next_s.tx_en = '1;
                rpc_pkg::RPC_LOCK: next_s.tx_en = '0;
                default: ;
            endcase
        end

        // Expansion port
        busy = (|crs_s) | (|pcol_s) | fifo_valid
            | (s.tx inside {rpc_pkg::RPC_PRE, rpc_pkg::RPC_DATA});
        next_s.exp.req_n = ~busy;
        next_s.exp.jam_oe = granted;
        next_s.exp.dat_oe = granted;
        next_s.exp.jam_o = (next_s.tx == rpc_pkg::RPC_JAM);
        next_s.exp.dat_o = (next_s.tx == rpc_pkg::RPC_JAM) ? single : next_s.tx_bit;

        // Carrier sense latch and serial output
        next_s.crs_latch = s.crs_latch | crs_s;
        next_s.crs_timer = s.crs_timer + 1'b1;
        if (s.crs_left != '0) begin
            next_s.crs_o = s.crs_shift[0];
            next_s.crs_shift = s.crs_shift >> 1;
            next_s.crs_left = s.crs_left - 1'b1;
            if (s.crs_left == 4'h1) begin
                next_s.str_cnt = `RPC_STR_CYC;
            end
        end
        if (s.crs_timer == 6'(CRS_CYC - 1)) begin
            next_s.crs_timer = '0;
            next_s.crs_shift = s.crs_latch | crs_s;
            next_s.crs_latch = crs_s;
            next_s.crs_left = `RPC_CRS_BITS;
        end
        if (s.str_cnt != '0) begin
            next_s.str_cnt = s.str_cnt - 1'b1;
        end
        next_s.str_o = s.str_oe & (s.str_cnt != '0);

        // Serial management and minimum mode status
        if (!s.min_mode) begin
            if (rise) begin
                next_s.cmd = {s.cmd[CMD_BITS-2:0], si_s};
                next_s.so = s.resp[CMD_BITS-1];
                next_s.resp = {s.resp[CMD_BITS-2:0], 1'b0};
                next_s.bcnt = s.bcnt + 1'b1;
                if (s.bcnt == 8'(CMD_BITS - 1)) begin
                    next_s.bcnt = '0;
                    if ({s.cmd[CMD_BITS-2:0], si_s} == OP_JABBER) begin
                        next_s.resp = {s.jabber, {(CMD_BITS - 1){1'b0}}};
                    end
                end
            end
        end else if (bit_en) begin
            unique case ({sclk_s, si_s})
                2'h0: sel = min_status.pol_sqe;
                2'h1: sel = min_status.rate_err;
                2'h2: sel = min_status.link_loop;
                2'h3: sel = min_status.part;
            endcase
            next_s.so = sel[s.midx];
            next_s.midx = (s.midx == 4'(NPORT - 1)) ? '0 : s.midx + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
            s.tx <= rpc_pkg::RPC_IDLE;
            s.exp.req_n <= `RPC_REQ_N_RESET;
            s.rst_d <= 1'b1;
            s.so <= `RPC_SO_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ***********************
    // Outputs
    // ***********************
    logic test_s_q;
    logic str_q;

    assign tx_en = s.tx_en;
    assign tx_bit = s.tx_bit;
    assign exp_out = s.exp;
    assign carrier_sense_serial_out = s.crs_o;
    assign store_strobe_o = s.str_o;
    assign store_strobe_oe = s.str_oe;
    assign so = s.so;
    assign minimum_mode = s.min_mode;
    assign polarity_correct_en = s.pol_en;
    assign loopback_allowed = test_s_q;
    assign jabber_lockup = s.jabber;
    assign store_strobe_in = str_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            test_s_q <= 1'b0;
            str_q <= 1'b0;
        end else begin
            test_s_q <= test_s;
            str_q <= str_s & ~s.str_oe;
        end
    end

endmodule : rpc_top

/* File: sim/rpc_top_sva.sv */
`timescale 1ns/1ps

module rpc_sva #(
    parameter int JABBER_BITS = 64
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Watched ports
    input wire logic [8:0] port_crs,
    input wire rpc_pkg::rpc_exp_in_t exp_in,
    input wire rpc_pkg::rpc_exp_out_t exp_out,
    input wire logic [8:0] tx_en,
    input wire logic tx_bit,
    input wire logic store_strobe_o,
    input wire logic store_strobe_oe,
    input wire logic jabber_lockup
);
    localparam int RUN_MAX = (JABBER_BITS + 2) * 4;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Cycles spent transmitting and locked out
    int run;
    int lock;
    always_ff @(posedge clk) begin
        run <= (rst || tx_en == 9'h000) ? 0 : run + 1;
        lock <= (rst || !jabber_lockup) ? 0 : lock + 1;
    end

    a_oe_on_grant: assert property (
        exp_out.dat_oe == (!$past(exp_in.ack_n, 3) && !$past(exp_out.req_n)))
        else $error("drive enable not tied to grant");
    a_jam_dat_pair: assert property (exp_out.jam_oe == exp_out.dat_oe)
        else $error("jam and data enables differ");
    a_dat_repeats: assert property (
        exp_out.dat_oe && !exp_out.jam_o |-> exp_out.dat_o == tx_bit)
        else $error("data line not repeating");
    a_req_active: assert property ((|port_crs) |-> ##3 !exp_out.req_n)
        else $error("no request on activity");
    a_jam_all_ports: assert property (
        $rose(exp_out.jam_o) |-> ##[0:4] tx_en == 9'h1FF)
        else $error("jam not sent to all ports");
    a_strobe_two: assert property (
        $rose(store_strobe_o) |=> store_strobe_o ##1 !store_strobe_o)
        else $error("store strobe width wrong");
    a_strobe_output: assert property (store_strobe_o |-> store_strobe_oe)
        else $error("strobe driven as input");
    a_sample_period: assert property (
        $rose(store_strobe_o) |-> ##40 $rose(store_strobe_o))
        else $error("carrier sample period wrong");
    a_jabber_bound: assert property (run <= RUN_MAX)
        else $error("transmission too long");
    a_lock_quiet: assert property (
        jabber_lockup && $past(jabber_lockup) |-> tx_en == 9'h000)
        else $error("transmit during lockout");
    a_lock_len: assert property (
        $fell(jabber_lockup) |-> lock >= 380 && lock <= 388)
        else $error("lockout length wrong");

    c_jam: cover property ($rose(exp_out.jam_o));
    c_lock: cover property ($rose(jabber_lockup));
    c_grant: cover property ($rose(exp_out.dat_oe));
endmodule : rpc_sva

/* File: sim/rpc_peer.sv */
`timescale 1ns/1ps

module rpc_peer (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bench control
    input wire logic [3:0] grant_wait,
    input wire logic other_active,
    // Expansion port
    input wire rpc_pkg::rpc_exp_out_t exp_out,
    output rpc_pkg::rpc_exp_in_t exp_in
);
    logic [3:0] cnt;
    logic ack_n;
    logic col_n;

    // ************
    // Arbiter
    // ************
    always_ff @(posedge clk) begin
        if (rst || exp_out.req_n) begin
            cnt <= 4'h0;
            ack_n <= 1'b1;
        end else if (cnt < grant_wait) begin
            cnt <= cnt + 4'h1;
        end else begin
            ack_n <= 1'b0;
        end
        col_n <= !(other_active && !exp_out.req_n && !rst);
    end

    // Pull-ups hold released lines high
    assign exp_in = '{ack_n: ack_n, col_n: col_n,
        jam: exp_out.jam_oe ? exp_out.jam_o : 1'b1,
        dat: exp_out.dat_oe ? exp_out.dat_o : 1'b1};
endmodule : rpc_peer

/* File: sim/rpc_top_tb.sv */
`timescale 1ns/1ps

module rpc_top_tb;
    localparam int JB = 128;
    localparam logic [7:0] OP = 8'hA5;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [8:0] port_crs = 9'h000;
    logic [8:0] port_col = 9'h000;
    rpc_pkg::rpc_min_status_t min_status = '0;
    logic rx_valid = 1'b0;
    logic rx_bit = 1'b0;
    logic stat_chip_present = 1'b0;
    logic stat_bit = 1'b1;
    logic sclk = 1'b0;
    logic si = 1'b1;
    logic test = 1'b0;
    logic [3:0] grant_wait = 4'h0;
    logic other_active = 1'b0;
    logic watch = 1'b0;
    logic rx_ready, tx_bit, so, store_strobe_o, store_strobe_oe, store_strobe_in;
    logic minimum_mode, polarity_correct_en, loopback_allowed, jabber_lockup, r;
    logic [8:0] tx_en;
    logic cs_out;
    logic [8:0] crsv = 9'h000;
    logic [17:0] win;
    logic [63:0] rnd;
    wire store_strobe_i;
    rpc_pkg::rpc_exp_in_t exp_in;
    rpc_pkg::rpc_exp_out_t exp_out;
    logic txq[$];
    logic jamq[$];
    int n_tests = 0;
    int n_mismatch = 0;
    int w;

    always #12.5 clk = ~clk;
    always @(posedge clk) crsv <= {cs_out, crsv[8:1]};
    assign store_strobe_i = store_strobe_oe ? store_strobe_o : stat_bit;

    rpc_top #(.NPORT(9), .JABBER_BITS(JB), .CMD_BITS(8), .OP_JABBER(OP), .FIFO_DEPTH(8)) DUT (
        .clk(clk), .rst(rst), .port_crs(port_crs), .port_col(port_col),
        .min_status(min_status), .rx_valid(rx_valid), .rx_bit(rx_bit), .rx_ready(rx_ready),
        .tx_en(tx_en), .tx_bit(tx_bit), .exp_in(exp_in), .exp_out(exp_out),
        .carrier_sense_serial_out(cs_out), .store_strobe_i(store_strobe_i),
        .store_strobe_o(store_strobe_o), .store_strobe_oe(store_strobe_oe),
        .stat_chip_present(stat_chip_present), .sclk(sclk), .si(si), .so(so), .test(test),
        .minimum_mode(minimum_mode), .polarity_correct_en(polarity_correct_en),
        .loopback_allowed(loopback_allowed), .jabber_lockup(jabber_lockup),
        .store_strobe_in(store_strobe_in));

    rpc_peer PEER (.clk(clk), .rst(rst), .grant_wait(grant_wait),
        .other_active(other_active), .exp_out(exp_out), .exp_in(exp_in));

    // ************
    // Tasks
    // ************
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic endt(input string s);
        $display("test %s done", s);
    endtask : endt

    task automatic results;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results

    task automatic reset_dut(input logic t, input logic s);
        test = t;
        stat_chip_present = s;
        rst = 1'b1;
        tick(4);
        rst = 1'b0;
        tick(6);
    endtask : reset_dut

    task automatic push(input logic b);
        rx_valid = 1'b1;
        rx_bit = b;
        for (int k = 0; k < 400; k++) begin
            @(posedge clk);
            if (rx_ready === 1'b1) break;
        end
        #1;
        txq.push_back(b);
    endtask : push

    task automatic mgmt(output logic res);
        for (int i = 0; i < 16; i++) begin
            si = (i < 8) ? OP[7 - i] : 1'b0;
            tick(4);
            sclk = 1'b1;
            tick(4);
            if (i == 8) res = so;
            sclk = 1'b0;
        end
    endtask : mgmt

    function automatic logic rot(input logic [17:0] s, input logic [8:0] v);
        for (int k = 0; k < 9; k++) begin
            if (s[k +: 9] === v) return 1'b1;
        end
        return 1'b0;
    endfunction : rot

    // ************
    // Result watchers
    // ************
    initial forever begin
        @(posedge clk iff (watch && tx_en != 9'h000));
        @(posedge clk);
        for (int i = 0; tx_en != 9'h000; i++) begin
            #2;
            if (i < 56) chk(tx_bit, !i[0]);
            else if (txq.size() > 0) chk(tx_bit, txq.pop_front());
            repeat (4) @(posedge clk);
        end
    end

    initial forever begin
        @(posedge clk iff exp_out.jam_o === 1'b1);
        #2;
        chk(exp_out.dat_o, jamq.pop_front());
        @(posedge clk iff exp_out.jam_o !== 1'b1);
    end

    initial begin
        #(20000 * 25);
        n_mismatch++;
        results();
    end

    // ************
    // Main sequence
    // ************
    initial begin
        void'($urandom(37532));
        reset_dut(1'b0, 1'b0);
        chk(minimum_mode, 0);
        chk(store_strobe_oe, 1);
        chk(exp_out.req_n, 1);
        endt("reset");

        grant_wait = 4'h9;
        watch = 1'b1;
        port_crs = 9'h004;
        for (w = 0; w < 300 && tx_en === 9'h000; w++) tick(1);
        chk(tx_en, ~port_crs);
        tick(41);
        @(posedge clk iff store_strobe_o === 1'b1);
        chk(crsv, 9'h004);
        #1;
        for (int i = 0; i < 8; i++) push(1'($urandom()));
        rx_valid = 1'b0;
        tick(2);
        chk(rx_ready, 0);
        for (int i = 0; i < 4; i++) push(1'($urandom()));
        rx_valid = 1'b0;
        port_crs = 9'h000;
        for (w = 0; w < 400 && tx_en !== 9'h000; w++) tick(1);
        chk(txq.size(), 0);
        watch = 1'b0;
        endt("repeat");

        grant_wait = 4'h0;
        for (int c = 0; c < 3; c++) begin
            jamq.push_back(c == 1);
            port_crs = (c == 0) ? 9'h003 : (c == 1) ? 9'h008 : 9'h001;
            port_col = (c == 1) ? 9'h008 : 9'h000;
            other_active = (c == 2);
            for (w = 0; w < 100 && exp_out.jam_o !== 1'b1; w++) tick(1);
            tick(8);
            chk(tx_en, 9'h1FF);
            port_crs = 9'h000;
            port_col = 9'h000;
            other_active = 1'b0;
            for (w = 0; w < 300 && (tx_en !== 9'h000 || exp_out.jam_o !== 1'b0); w++) tick(1);
            tick(8);
        end
        endt("collision");

        port_crs = 9'h020;
        for (w = 0; w < 800 && jabber_lockup !== 1'b1; w++) tick(1);
        tick(4);
        chk(tx_en, 9'h000);
        port_crs = 9'h000;
        mgmt(r);
        chk(r, 1);
        for (w = 0; w < 500 && jabber_lockup !== 1'b0; w++) tick(1);
        mgmt(r);
        chk(r, 0);
        endt("jabber");

        si = 1'b1;
        reset_dut(1'b1, 1'b1);
        chk(minimum_mode, 1);
        chk(polarity_correct_en, 1);
        chk(loopback_allowed, 1);
        chk(store_strobe_oe, 0);
        stat_bit = 1'b0;
        tick(5);
        chk(store_strobe_in, 0);
        for (int m = 0; m < 4; m++) begin
            {sclk, si} = 2'(m);
            rnd = {$urandom(), $urandom()};
            min_status = rnd[35:0];
            tick(12);
            for (int k = 0; k < 18; k++) begin
                win[k] = so;
                tick(4);
            end
            chk(rot(win, min_status[35 - 9 * m -: 9]), 1);
        end
        endt("minimum");
        results();
    end
endmodule : rpc_top_tb

bind rpc_top rpc_sva #(.JABBER_BITS(JABBER_BITS)) u_sva (.clk(clk), .rst(rst),
    .port_crs(port_crs), .exp_in(exp_in), .exp_out(exp_out), .tx_en(tx_en), .tx_bit(tx_bit),
    .store_strobe_o(store_strobe_o), .store_strobe_oe(store_strobe_oe),
    .jabber_lockup(jabber_lockup));
